// *** design/sodc_decoder.sv ***
// Serial opcode decoder with daisy-chain readout
`timescale 1ns/1ps
// How it works
// - Daisy chaining only when config bit set
// - No repeated read-by-command in daisy mode
// - Rising edge shifts out, latches daisy in
// - System opcodes decode on seventh falling edge, except 10h/11h on eighth
// - Register opcodes decode on eighth falling edge
// - Wakeup, standby, reset, start, stop codes
// - Continuous, stop continuous, single read codes
// - Register read: 001 address, 000 count
// - Register write: 010 address, 000 count
// - Register read ignored in continuous mode
// - Standby accepts only wakeup
// - Reset restores defaults within eighteen clocks
// - Start begins conversions, else no effect
// - Stop finishes current conversion, then halts
// - Continuous read is default, loads each result
// - Continuous mode accepts only stop continuous
// - Register data leaves from seventeenth rising edge
// - Write data follows opcodes, MSB first
module sodc_decoder #(
	parameter int RESULT_W = sodc_pkg::RESULT_BITS,
	parameter int FIFO_D = sodc_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic daisy_in,
	input wire logic start_pin,
	input wire logic conversion_done,
	input wire logic [RESULT_W-1:0] result_data,
	input wire logic [7:0] reg_rd_data,
	input wire logic wr_ready,
	output logic dout,
	output logic dout_oe,
	output logic conversion_ready_n,
	output logic converting,
	output logic standby,
	output logic soft_reset,
	output logic daisy_enable,
	output logic read_continuous,
	output logic [4:0] reg_addr,
	output logic reg_rd_strobe,
	output logic wr_valid,
	output logic [4:0] wr_addr,
	output logic [7:0] wr_data
);
	logic [3:0] pin_lvl;
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;
	logic cs_n_s;
	logic sck_rise;
	logic sck_fall;
	logic din_s;
	logic [7:0] shift_q;
	logic [2:0] bit_q;
	logic byte_done;
	logic [7:0] rx_byte;
	sodc_pkg::sodc_state_type state_q;
	logic [2:0] op_pfx_q;
	logic [4:0] addr_q;
	logic [4:0] cnt_q;
	logic [RESULT_W-1:0] out_q;
	logic out_bit_q;
	logic readback_q;
	logic [7:0] cfg1_q;
	logic [4:0] rst_cnt_q;
	logic run_q;
	logic stop_pend_q;
	logic standby_q;
	logic rdc_q;
	logic rdy_n_q;
	logic cfg_we;
	sodc_stream_if #(.WIDTH(sodc_pkg::DATA_WIDTH)) to_fifo();
	sodc_stream_if #(.WIDTH(sodc_pkg::DATA_WIDTH)) from_fifo();

	sodc_sync #(.WIDTH(4)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({~cs_n, sclk, din, daisy_in}),
		.level_out(pin_lvl),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);
	// Select enters inverted so reset level equals idle, no false select
	assign cs_n_s = !pin_lvl[3];
	assign sck_rise = pin_rise[2] && !cs_n_s;
	assign sck_fall = pin_fall[2] && !cs_n_s;
	assign din_s = pin_lvl[1];

	// Start pin is level only; registered twice to stay clean
	logic start_s1_q;
	logic start_s2_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_s1_q <= 1'b0;
			start_s2_q <= 1'b0;
		end else begin
			start_s1_q <= start_pin;
			start_s2_q <= start_s1_q;
		end
	end

	assign rx_byte = {shift_q[6:0], din_s};
	assign byte_done = sck_fall && (bit_q == 3'd7);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= '0;
			bit_q <= '0;
		end else if (cs_n_s) begin
			bit_q <= '0;
		end else if (sck_fall) begin
			shift_q <= rx_byte;
			bit_q <= bit_q + 3'd1;
		end
	end

	function automatic logic is_sys(input logic [7:0] b);
		is_sys = (b == sodc_pkg::OP_WAKEUP) || (b == sodc_pkg::OP_STANDBY) || (b == sodc_pkg::OP_RESET)
			|| (b == sodc_pkg::OP_START) || (b == sodc_pkg::OP_STOP) || (b == sodc_pkg::OP_READ_CONT)
			|| (b == sodc_pkg::OP_STOP_CONT) || (b == sodc_pkg::OP_READ_ONE);
	endfunction

	// Seven-bit prefix known at seventh edge; low bit ends the code
	logic sys_hit;
	assign sys_hit = sck_fall && (bit_q == 3'd6) && (state_q == sodc_pkg::SODC_OP1)
		&& is_sys({shift_q[5:0], din_s, 1'b0} | 8'h00) ;
	logic [7:0] seven_code;
	assign seven_code = {shift_q[5:0], din_s, 1'b0};

	// System commands act on the even code seen at edge seven; 10h/11h need bit 0
	logic cmd_fire;
	logic [7:0] cmd;
	assign cmd_fire = byte_done && (state_q == sodc_pkg::SODC_OP1) && is_sys(rx_byte);
	assign cmd = rx_byte;
	logic early_fire;
	assign early_fire = sys_hit && (seven_code != sodc_pkg::OP_READ_CONT) && (seven_code != sodc_pkg::OP_STOP_CONT);

	logic accept;
	// continuous mode accepts only stop continuous
	function automatic logic allowed(input logic [7:0] c, input logic sb, input logic rc);
		if (sb) allowed = (c == sodc_pkg::OP_WAKEUP);
		else if (rc) allowed = (c == sodc_pkg::OP_STOP_CONT);
		else allowed = 1'b1;
	endfunction
	assign accept = early_fire ? allowed(seven_code, standby_q, rdc_q)
		: (cmd_fire && (cmd[7:1] == 7'h08) && allowed(cmd, standby_q, rdc_q));

	logic [7:0] act;
	assign act = early_fire ? seven_code : cmd;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= sodc_pkg::SODC_OP1;
			op_pfx_q <= '0;
			addr_q <= '0;
			cnt_q <= '0;
		end else if (cs_n_s || rst_cnt_q != 5'd0) begin
			state_q <= sodc_pkg::SODC_OP1;
		end else if (byte_done) begin
			case (state_q)
				sodc_pkg::SODC_OP1: begin
					op_pfx_q <= rx_byte[7:5];
					addr_q <= rx_byte[4:0];
					if (!standby_q && !rdc_q && (rx_byte[7:5] == sodc_pkg::PFX_REG_READ
						|| rx_byte[7:5] == sodc_pkg::PFX_REG_WRITE)) begin
						state_q <= sodc_pkg::SODC_OP2;
					end
				end
				// second byte carries count less one
				sodc_pkg::SODC_OP2: begin
					cnt_q <= rx_byte[4:0];
					if (rx_byte[7:5] != sodc_pkg::PFX_COUNT) begin
						state_q <= sodc_pkg::SODC_SKIP;
					end else if (op_pfx_q == sodc_pkg::PFX_REG_READ) begin
						state_q <= sodc_pkg::SODC_RDOUT;
					end else begin
						state_q <= sodc_pkg::SODC_WRIN;
					end
				end
				sodc_pkg::SODC_WRIN: begin
					addr_q <= addr_q + 5'd1;
					cnt_q <= cnt_q - 5'd1;
					if (cnt_q == 5'd0) begin
						state_q <= sodc_pkg::SODC_SKIP;
					end
				end
				sodc_pkg::SODC_RDOUT: begin
					addr_q <= addr_q + 5'd1;
					cnt_q <= cnt_q - 5'd1;
					if (cnt_q == 5'd0) begin
						state_q <= sodc_pkg::SODC_SKIP;
					end
				end
				sodc_pkg::SODC_SKIP, sodc_pkg::SODC_DATA: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= sodc_pkg::SODC_OP1;
				end
			endcase
		end
	end

	assign to_fifo.valid = byte_done && (state_q == sodc_pkg::SODC_WRIN);
	assign to_fifo.data = rx_byte;
	sodc_fifo #(.WIDTH(sodc_pkg::DATA_WIDTH), .DEPTH(FIFO_D)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_s(to_fifo),
		.out_s(from_fifo)
	);
	logic [4:0] wr_addr_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_addr_q <= '0;
		end else if (byte_done && state_q == sodc_pkg::SODC_OP1) begin
			wr_addr_q <= rx_byte[4:0];
		end else if (from_fifo.valid && from_fifo.ready) begin
			wr_addr_q <= wr_addr_q + 5'd1;
		end
	end
	assign from_fifo.ready = wr_ready;
	assign wr_valid = from_fifo.valid;
	assign wr_data = from_fifo.data;
	assign wr_addr = wr_addr_q;
	assign cfg_we = from_fifo.valid && wr_ready && (wr_addr_q == sodc_pkg::FIRST_CONFIG_REGISTER_ADDR);

	// daisy enable from first configuration register
	// reset restores defaults, holds off commands
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg1_q <= sodc_pkg::FIRST_CONFIG_REGISTER_RESET;
			rst_cnt_q <= '0;
		end else if (accept && act == sodc_pkg::OP_RESET) begin
			cfg1_q <= sodc_pkg::FIRST_CONFIG_REGISTER_RESET;
			rst_cnt_q <= 5'(sodc_pkg::RESET_TCLK);
		end else begin
			if (cfg_we) cfg1_q <= wr_data;
			if (rst_cnt_q != 5'd0) rst_cnt_q <= rst_cnt_q - 5'd1;
		end
	end
	assign daisy_enable = cfg1_q[sodc_pkg::DAISY_EN_BIT];
	assign soft_reset = (rst_cnt_q != 5'd0);

	// start command has no effect while the start pin is high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 1'b0;
			stop_pend_q <= 1'b0;
			standby_q <= 1'b0;
		end else if (soft_reset) begin
			run_q <= 1'b0;
			stop_pend_q <= 1'b0;
		end else begin
			if (accept && act == sodc_pkg::OP_START && !start_s2_q) begin
				run_q <= 1'b1;
				stop_pend_q <= 1'b0;
			end else if (accept && act == sodc_pkg::OP_STOP && run_q) begin
				stop_pend_q <= 1'b1;
			end else if (stop_pend_q && conversion_done) begin
				run_q <= 1'b0;
				stop_pend_q <= 1'b0;
			end
			if (accept && act == sodc_pkg::OP_STANDBY) standby_q <= 1'b1;
			else if (accept && act == sodc_pkg::OP_WAKEUP) standby_q <= 1'b0;
		end
	end
	assign converting = run_q || start_s2_q;
	assign standby = standby_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdc_q <= 1'b1;
		end else if (soft_reset) begin
			rdc_q <= 1'b1;
		end else if (accept && act == sodc_pkg::OP_STOP_CONT) begin
			rdc_q <= 1'b0;
		end else if (accept && act == sodc_pkg::OP_READ_CONT) begin
			rdc_q <= 1'b1;
		end
	end
	assign read_continuous = rdc_q;

	// Ready falls on a fresh result, rises on first shift clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdy_n_q <= 1'b1;
		end else if (conversion_done && converting) begin
			rdy_n_q <= 1'b0;
		end else if (sck_fall) begin
			rdy_n_q <= 1'b1;
		end
	end
	assign conversion_ready_n = rdy_n_q;

	// rising edge shifts out and latches daisy in
	// first register bit on edge seventeen
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_q <= '0;
			out_bit_q <= 1'b0;
			readback_q <= 1'b0;
		end else begin
			if (conversion_done && converting && (rdc_q || cs_n_s)) begin
				out_q <= result_data;
				readback_q <= 1'b1;
			end else if (accept && act == sodc_pkg::OP_READ_ONE && (readback_q || !daisy_enable)) begin
				out_q <= result_data;
				readback_q <= 1'b0;
			end else if (byte_done && state_q == sodc_pkg::SODC_OP2 && op_pfx_q == sodc_pkg::PFX_REG_READ) begin
				out_q <= {reg_rd_data, {(RESULT_W-8){1'b0}}};
			end else if (byte_done && state_q == sodc_pkg::SODC_RDOUT) begin
				out_q <= {reg_rd_data, {(RESULT_W-8){1'b0}}};
			end else if (sck_rise) begin
				out_bit_q <= out_q[RESULT_W-1];
				// extra clock passes daisy bit through
				out_q <= {out_q[RESULT_W-2:0], daisy_enable ? pin_lvl[0] : 1'b0};
			end
		end
	end
	assign reg_addr = addr_q;
	assign reg_rd_strobe = byte_done && (state_q == sodc_pkg::SODC_OP2 || state_q == sodc_pkg::SODC_RDOUT);
	assign dout = out_bit_q;
	assign dout_oe = !cs_n_s;
endmodule

// *** pkg/sodc_pkg.sv ***
// Package of constants and types for the serial opcode decoder
package sodc_pkg;
	localparam logic [7:0] OP_WAKEUP = 8'h02;
	localparam logic [7:0] OP_STANDBY = 8'h04;
	localparam logic [7:0] OP_RESET = 8'h06;
	localparam logic [7:0] OP_START = 8'h08;
	localparam logic [7:0] OP_STOP = 8'h0A;
	localparam logic [7:0] OP_READ_CONT = 8'h10;
	localparam logic [7:0] OP_STOP_CONT = 8'h11;
	localparam logic [7:0] OP_READ_ONE = 8'h12;
	localparam logic [2:0] PFX_REG_READ = 3'h1;
	localparam logic [2:0] PFX_REG_WRITE = 3'h2;
	localparam logic [2:0] PFX_COUNT = 3'h0;
	localparam int SYS_DECODE_EDGE = 7;
	localparam int REG_DECODE_EDGE = 8;
	localparam int RESET_TCLK = 18;
	localparam int DAISY_EN_BIT = 6;
	localparam logic [7:0] FIRST_CONFIG_REGISTER_RESET = 8'h06;
	localparam logic [4:0] FIRST_CONFIG_REGISTER_ADDR = 5'h01;
	localparam int DATA_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int RESULT_BITS = 216;
	typedef enum logic [5:0] {
		SODC_OP1 = 6'h01,
		SODC_OP2 = 6'h02,
		SODC_RDOUT = 6'h04,
		SODC_WRIN = 6'h08,
		SODC_SKIP = 6'h10,
		SODC_DATA = 6'h20
	} sodc_state_type;
endpackage

// *** pkg/sodc_stream_if.sv ***
// Interface carrying bytes between the decoder and its buffer
`timescale 1ns/1ps
interface sodc_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source(output valid, output data, input ready);
	modport sink(input valid, input data, output ready);
endinterface

// *** design/sodc_fifo.sv ***
// Parameterised FIFO for received write data bytes
`timescale 1ns/1ps
module sodc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	sodc_stream_if.sink in_s,
	sodc_stream_if.source out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;
	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
		end else if (in_s.valid && !full) begin
			wr_q <= wr_q + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (in_s.valid && !full) begin
			mem_q[wr_q[AW-1:0]] <= in_s.data;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= '0;
		end else if (out_s.ready && !empty) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// *** design/sodc_sync.sv ***
// Two flip-flop synchroniser with edge detection on the clean copy
`timescale 1ns/1ps
module sodc_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out,
	output logic [WIDTH-1:0] fall_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;
	// First stage feeds only the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign level_out = sync_q;
	assign rise_out = sync_q & ~prev_q;
	assign fall_out = ~sync_q & prev_q;
endmodule

// *** tb/sodc_host.sv ***
// Host controller model driving the serial command pins
`timescale 1ns/1ps
module sodc_host (
	input wire logic clk,
	input wire logic dout,
	output logic cs_n,
	output logic sclk,
	output logic din
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b1;
	end
	task automatic open_frame();
		@(posedge clk);
		#1 cs_n = 1'b0;
		#100;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			din = tx[i];
			#100 sclk = 1'b0;
			#50 rx[i] = dout;
			#50;
		end
		#200;
	endtask
	// one extra clock between data sets
	task automatic extra_clock();
		sclk = 1'b1;
		#100 sclk = 1'b0;
		#100;
	endtask
	task automatic close_frame();
		cs_n = 1'b1;
		// Released line must not look held
		din = ~din;
		#600;
	endtask
endmodule

// *** tb/sodc_monitor.sv ***
// Concurrent checks on the decoder's ports
`timescale 1ns/1ps
module sodc_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic conversion_done,
	input wire logic conversion_ready_n,
	input wire logic converting,
	input wire logic standby,
	input wire logic soft_reset,
	input wire logic daisy_enable,
	input wire logic read_continuous,
	input wire logic reg_rd_strobe,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [4:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic sclk_q;
	logic [3:0] rise_age_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end
	// Saturates so a quiet link never wraps
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_age_q <= 4'hF;
		end else if (sclk && !sclk_q) begin
			rise_age_q <= 4'h0;
		end else if (rise_age_q != 4'hF) begin
			rise_age_q <= rise_age_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_conv_end;
		converting && conversion_done;
	endsequence
	property p_ready_on_result;
		s_conv_end |-> ##[1:3] !conversion_ready_n;
	endproperty
	a_ready_on_result: assert property (p_ready_on_result) else $error("result not flagged");
	property p_start_gated;
		$rose(converting) |-> !$past(read_continuous) && !$past(standby);
	endproperty
	a_start_gated: assert property (p_start_gated) else $error("start taken in continuous mode");
	property p_standby_gated;
		$rose(read_continuous) |-> !$past(standby);
	endproperty
	a_standby_gated: assert property (p_standby_gated) else $error("command taken in standby");
	property p_stop_after_result;
		$fell(converting) |-> $past(conversion_done) || $past(conversion_done, 2) || $past(soft_reset) || $past(soft_reset, 2);
	endproperty
	a_stop_after_result: assert property (p_stop_after_result) else $error("conversion cut short");
	property p_reset_defaults;
		$rose(soft_reset) |-> ##[0:18] !daisy_enable;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("defaults late after reset");
	property p_write_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_addr);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write byte dropped while stalled");
	property p_shift_on_rise;
		dout_oe && $changed(dout) |-> rise_age_q <= 4'h6;
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise) else $error("dout moved without rising edge");
	property p_no_read_in_cont;
		read_continuous |-> !reg_rd_strobe;
	endproperty
	a_no_read_in_cont: assert property (p_no_read_in_cont) else $error("register read in continuous mode");
endmodule
bind sodc_decoder sodc_monitor u_mon (.clk, .reset_n, .sclk, .dout, .dout_oe, .conversion_done,
	.conversion_ready_n, .converting, .standby, .soft_reset, .daisy_enable, .read_continuous,
	.reg_rd_strobe, .wr_valid, .wr_ready, .wr_addr, .wr_data);

// *** tb/spi_opcode_decoder_daisy_chain_bench.sv ***
// Self-checking bench for the serial opcode decoder
`timescale 1ns/1ps
module spi_opcode_decoder_daisy_chain_bench;
	typedef struct packed {
		logic [7:0] op;
		logic conv;
		logic stby;
		logic rc;
	} sodc_row_type;
	logic clk, reset_n, start_pin, daisy_in, conversion_done, wr_ready, cs_n, sclk, din;
	logic [sodc_pkg::RESULT_BITS-1:0] result_data;
	logic [7:0] reg_rd_data, wr_data, rx;
	logic [4:0] reg_addr, wr_addr;
	logic dout, dout_oe, conversion_ready_n, converting, standby, soft_reset, daisy_enable, read_continuous;
	logic reg_rd_strobe, wr_valid;
	int fails, num_checks, n;
	// Refusals interleaved with accepted codes
	sodc_row_type rows [10] = '{
		'{8'h08, 1'b0, 1'b0, 1'b1},
		'{8'h11, 1'b0, 1'b0, 1'b0},
		'{8'h04, 1'b0, 1'b1, 1'b0},
		'{8'h08, 1'b0, 1'b1, 1'b0},
		'{8'h02, 1'b0, 1'b0, 1'b0},
		'{8'h08, 1'b1, 1'b0, 1'b0},
		'{8'h08, 1'b1, 1'b0, 1'b0},
		'{8'h10, 1'b1, 1'b0, 1'b1},
		'{8'h0A, 1'b1, 1'b0, 1'b1},
		'{8'h11, 1'b1, 1'b0, 1'b0}
	};
	sodc_decoder dut (.clk, .reset_n, .cs_n, .sclk, .din, .daisy_in, .start_pin, .conversion_done, .result_data,
		.reg_rd_data, .wr_ready, .dout, .dout_oe, .conversion_ready_n, .converting, .standby, .soft_reset,
		.daisy_enable, .read_continuous, .reg_addr, .reg_rd_strobe, .wr_valid, .wr_addr, .wr_data);
	sodc_host host (.clk, .dout, .cs_n, .sclk, .din);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Register bytes echo their address
	always_comb reg_rd_data = {3'b101, reg_addr};
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic send1(input logic [7:0] op);
		host.open_frame();
		host.xfer(op, rx);
		host.close_frame();
	endtask
	initial begin
		reset_n = 1'b0;
		start_pin = 1'b0;
		daisy_in = 1'b0;
		conversion_done = 1'b0;
		wr_ready = 1'b0;
		result_data = '0;
		fails = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		chk("read_continuous", 8'h01, read_continuous);
		chk("dout_oe", 8'h00, dout_oe);
		for (int i = 0; i < 10; i++) begin
			send1(rows[i].op);
			chk("converting", rows[i].conv, converting);
			chk("standby", rows[i].stby, standby);
			chk("read_continuous", rows[i].rc, read_continuous);
		end
		send1(8'h0A);
		chk("converting", 8'h01, converting);
		@(posedge clk);
		#1 conversion_done = 1'b1;
		@(posedge clk);
		#1 conversion_done = 1'b0;
		repeat (4) @(posedge clk);
		chk("conversion_ready_n", 8'h00, conversion_ready_n);
		chk("converting", 8'h00, converting);
		send1(8'h0A);
		chk("converting", 8'h00, converting);
		host.open_frame();
		host.xfer(8'h25, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h00, rx);
		host.close_frame();
		chk("read byte", 8'hA5, rx);
		// Nine bytes into eight slots, consumer stalled
		host.open_frame();
		host.xfer(8'h43, rx);
		host.xfer(8'h08, rx);
		for (int i = 0; i < 9; i++) begin
			host.xfer(8'h30 + i[7:0], rx);
		end
		host.close_frame();
		chk("wr_addr", 8'h03, {3'b000, wr_addr});
		n = 0;
		@(posedge clk);
		#1 wr_ready = 1'b1;
		repeat (40) begin
			@(negedge clk);
			if (wr_valid === 1'b1) begin
				chk("wr_data", 8'h30 + n[7:0], wr_data);
				chk("wr_addr", 8'h03 + n[7:0], {3'b000, wr_addr});
				n++;
			end
		end
		chk("fifo count", 8'(sodc_pkg::FIFO_DEPTH), n[7:0]);
		host.open_frame();
		host.xfer(8'h41, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h46, rx);
		host.close_frame();
		chk("daisy_enable", 8'h01, daisy_enable);
		host.open_frame();
		host.extra_clock();
		host.close_frame();
		chk("daisy_enable", 8'h01, daisy_enable);
		send1(8'h06);
		chk("daisy_enable", 8'h00, daisy_enable);
		chk("soft_reset", 8'h00, soft_reset);
		report_and_stop();
	end
	// Hang guard
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
endmodule
